// [dv/tcu_pins_model.sv]
// pin-side model: capture and kill sources for the five units
module tcu_pins_model
	import tcu_pkg::*;
(
	// clock
	input wire logic hclk,
	// requests from the bench
	input wire logic [NUM_UNITS-1:0] cap_req,
	input wire logic [NUM_UNITS-1:0] kill_req,
	// pins
	output logic [NUM_UNITS-1:0] capture_pin,
	output logic [NUM_UNITS-1:0] kill_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		capture_pin = 5'h00;
		kill_pin = 5'h00;
	end

	// pins move mid-cycle: real sources know nothing of hclk
	always @(posedge hclk) begin
		#3;
		capture_pin = cap_req;
		kill_pin = kill_req;
	end
endmodule // tcu_pins_model

// [dv/tcu_top_tb_top.sv]
// self-checking bench for the five-unit timer/pwm block
module tcu_top_tb_top
	import tcu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic [NUM_UNITS-1:0] cap_req = 5'h00;
	logic [NUM_UNITS-1:0] kill_req = 5'h00;
	logic [NUM_UNITS-1:0] capture_pin;
	logic [NUM_UNITS-1:0] kill_pin;
	logic [NUM_UNITS-1:0] pwm_out;
	logic [NUM_UNITS-1:0] pwm_out_n;
	int err_count = 0;
	int checks_done = 0;
	logic [31:0] exp_q[$];
	logic rd_dp = 1'b0;

	always #5 hclk = ~hclk;

	tcu_top tcu_top_i (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .capture_pin(capture_pin), .kill_pin(kill_pin),
		.pwm_out(pwm_out), .pwm_out_n(pwm_out_n)
	);

	tcu_pins_model tcu_pins_model_i (
		.hclk(hclk), .cap_req(cap_req), .kill_req(kill_req),
		.capture_pin(capture_pin), .kill_pin(kill_pin)
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic bus(input logic w, input int u, input logic [2:0] r,
		input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, u[2:0], r, 2'h0};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask

	task automatic wr(input int u, input logic [2:0] r, input logic [31:0] d);
		bus(1'b1, u, r, d);
	endtask

	task automatic rd(input int u, input logic [2:0] r, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, u, r, 32'h0);
	endtask

	// read answers are matched in issue order against the noted values
	always @(posedge hclk) begin
		if (rd_dp && hreadyout === 1'b1) begin
			chk(hrdata, exp_q.pop_front());
			chk({31'h0, hresp}, 32'h0);
			rd_dp = 1'b0;
		end
		if (hsel && htrans[1] && !hwrite && hreadyout === 1'b1)
			rd_dp = 1'b1;
	end

	initial begin : main
		logic [31:0] rst_v[7] = '{32'h0, 32'hffff, 32'h0, 32'h0, 32'h0,
			32'h0, 32'h0};
		int dd[NUM_UNITS] = '{0, 2, 0, 0, 0};
		int c[NUM_UNITS] = '{0, 5, 0, 0, 12};
		logic [31:0] hi[NUM_UNITS] = '{default: 32'h0};
		logic [31:0] lo[NUM_UNITS] = '{default: 32'h0};
		logic [31:0] ov = 32'h0;
		int full;
		void'($urandom(32'h64b1));
		c[2] = $urandom_range(11, 0);
		c[3] = $urandom_range(11, 0);
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		// unit 5 and register 7 are holes and must read zero
		for (int u = 0; u < 6; u++)
			for (int r = 0; r < 8; r++)
				rd(u, r[2:0], (u < 5 && r < 7) ? rst_v[r] : 32'h0);
		wr(6, REG_CMP, 32'h1234);
		rd(6, REG_CMP, 32'h0);
		wr(0, REG_PERIOD, 32'hffff_1234);
		rd(0, REG_PERIOD, 32'h1234);
		for (int u = 0; u < NUM_UNITS; u++) begin
			wr(u, REG_PERIOD, 32'h9);
			wr(u, REG_CMP, 32'(c[u]));
			wr(u, REG_DEAD, 32'(dd[u]));
			wr(u, REG_CTRL, 32'h3);
		end
		repeat (30) @(posedge hclk);
		// 100 cycles span whole periods of ten counts each
		repeat (100) begin
			@(posedge hclk);
			for (int u = 0; u < NUM_UNITS; u++) begin
				hi[u] += pwm_out[u];
				lo[u] += pwm_out_n[u];
				ov += pwm_out[u] & pwm_out_n[u];
			end
		end
		for (int u = 0; u < NUM_UNITS; u++) begin
			full = (c[u] > 9 ? 10 : c[u]) * 10;
			chk(hi[u], full - dd[u] * 10);
			chk(lo[u], 100 - full - dd[u] * 10);
		end
		chk(ov, 0);
		wr(2, REG_CTRL, 32'h0);
		wr(2, REG_PERIOD, 32'h5);
		wr(2, REG_CTRL, 32'h1);
		repeat (20) @(posedge hclk);
		rd(2, REG_COUNT, 32'h5);
		rd(2, REG_STAT, 32'h1);
		cap_req[2] <= 1'b1;
		repeat (8) @(posedge hclk);
		cap_req[2] <= 1'b0;
		rd(2, REG_CAPT, 32'h5);
		rd(2, REG_STAT, 32'h5);
		wr(2, REG_STAT, 32'h4);
		rd(2, REG_STAT, 32'h1);
		wr(2, REG_CTRL, 32'h0);
		rd(2, REG_COUNT, 32'h0);
		rd(2, REG_STAT, 32'h0);
		// kill levels chosen opposite to the running levels of unit 4
		wr(4, REG_CTRL, 32'hb);
		kill_req[4] <= 1'b1;
		repeat (5) @(posedge hclk);
		chk({pwm_out[4], pwm_out_n[4]}, 32'h1);
		rd(4, REG_STAT, 32'h2);
		kill_req[4] <= 1'b0;
		repeat (6) @(posedge hclk);
		chk({pwm_out[4], pwm_out_n[4]}, 32'h2);
		repeat (5) @(posedge hclk);
		give_verdict();
	end

	initial begin
		repeat (20000) @(posedge hclk);
		err_count++;
		give_verdict();
	end
endmodule // tcu_top_tb_top

// [logic/tcu_top.sv]
// five timer/counter/pwm units behind an ahb-lite register slave

// Functional notes
// - sixteen-bit counter, period set by software
// - capture event latches current count
// - at period match, halt or reload
// - compare values set pwm duty
// - true and complement with dead band
// - kill forces outputs to preset state
// - five independent units
module tcu_top
	import tcu_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// event pins
	input wire logic [NUM_UNITS-1:0] capture_pin,
	input wire logic [NUM_UNITS-1:0] kill_pin,
	// pwm pins
	output logic [NUM_UNITS-1:0] pwm_out,
	output logic [NUM_UNITS-1:0] pwm_out_n
);
	function automatic logic [2:0] unit_of(input logic [7:0] a);
		return a[UNIT_LSB +: 3];
	endfunction

	function automatic logic [2:0] reg_of(input logic [7:0] a);
		return a[REG_LSB +: 3];
	endfunction

	// pin synchronisers, stage one feeds only stage two
	logic [NUM_UNITS-1:0] cap_s1_r, cap_s2_r, cap_s3_r;
	logic [NUM_UNITS-1:0] kill_s1_r, kill_s2_r;
	logic [NUM_UNITS-1:0] cap_evt;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cap_s1_r <= '0;
			cap_s2_r <= '0;
			cap_s3_r <= '0;
			kill_s1_r <= '0;
			kill_s2_r <= '0;
		end else begin
			cap_s1_r <= capture_pin;
			cap_s2_r <= cap_s1_r;
			cap_s3_r <= cap_s2_r;
			kill_s1_r <= kill_pin;
			kill_s2_r <= kill_s1_r;
		end
	end

	// capture on the rising edge of the pin
	assign cap_evt = cap_s2_r & ~cap_s3_r;

	// bus state
	tcu_bus_st_t bus_st_r, bus_st_nxt;
	logic [7:0] addr_r, addr_nxt;
	logic wr_pend_r, wr_pend_nxt;
	logic hreadyout_r, hreadyout_nxt;
	logic [31:0] hrdata_r, hrdata_nxt;
	logic acc;
	logic [31:0] rd_val;

	// register state
	logic [CTRL_W-1:0] ctrl_r [NUM_UNITS];
	logic [CTRL_W-1:0] ctrl_nxt [NUM_UNITS];
	logic [CNT_W-1:0] period_r [NUM_UNITS];
	logic [CNT_W-1:0] period_nxt [NUM_UNITS];
	logic [CNT_W-1:0] cmp_r [NUM_UNITS];
	logic [CNT_W-1:0] cmp_nxt [NUM_UNITS];
	logic [DEAD_W-1:0] dead_r [NUM_UNITS];
	logic [DEAD_W-1:0] dead_nxt [NUM_UNITS];
	logic [NUM_UNITS-1:0] cap_flag_r, cap_flag_nxt;

	// unit state
	logic [CNT_W-1:0] count_w [NUM_UNITS];
	logic [CNT_W-1:0] capt_w [NUM_UNITS];
	logic [NUM_UNITS-1:0] halted_w;

	// the slave decodes only haddr[7:0]; hsel comes from the interconnect
	assign acc = hsel && htrans[1] && hready;

	// reads take one wait state so a write just before is always seen
	always_comb begin
		bus_st_nxt = bus_st_r;
		addr_nxt = addr_r;
		wr_pend_nxt = 1'b0;
		hreadyout_nxt = 1'b1;
		hrdata_nxt = hrdata_r;
		case (bus_st_r)
			BUS_IDLE: begin
				if (acc) begin
					addr_nxt = haddr[7:0];
					if (hwrite) begin
						wr_pend_nxt = 1'b1;
					end else begin
						bus_st_nxt = BUS_RDWAIT;
						hreadyout_nxt = 1'b0;
					end
				end
			end
			BUS_RDWAIT: begin
				hrdata_nxt = rd_val;
				bus_st_nxt = BUS_IDLE;
			end
			default: begin
				bus_st_nxt = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_st_r <= BUS_IDLE;
			addr_r <= 8'h00;
			wr_pend_r <= 1'b0;
			hreadyout_r <= 1'b1;
			hrdata_r <= 32'h00000000;
		end else begin
			bus_st_r <= bus_st_nxt;
			addr_r <= addr_nxt;
			wr_pend_r <= wr_pend_nxt;
			hreadyout_r <= hreadyout_nxt;
			hrdata_r <= hrdata_nxt;
		end
	end

	assign hreadyout = hreadyout_r;
	assign hrdata = hrdata_r;
	assign hresp = 1'b0;

	// read mux; unmapped units and registers read as zero
	always_comb begin
		logic [2:0] u;
		u = unit_of(addr_r);
		rd_val = 32'h00000000;
		if (u <= UNIT_LAST) begin
			case (reg_of(addr_r))
				REG_CTRL: rd_val[CTRL_W-1:0] = ctrl_r[u];
				REG_PERIOD: rd_val[CNT_W-1:0] = period_r[u];
				REG_CMP: rd_val[CNT_W-1:0] = cmp_r[u];
				REG_DEAD: rd_val[DEAD_W-1:0] = dead_r[u];
				REG_COUNT: rd_val[CNT_W-1:0] = count_w[u];
				REG_CAPT: rd_val[CNT_W-1:0] = capt_w[u];
				REG_STAT: begin
					rd_val[STAT_HALT] = halted_w[u];
					rd_val[STAT_KILL] = kill_s2_r[u];
					rd_val[STAT_CAP] = cap_flag_r[u];
				end
				default: rd_val = 32'h00000000;
			endcase
		end
	end

	// register writes land in the data phase
	always_comb begin
		logic [2:0] u;
		u = unit_of(addr_r);
		ctrl_nxt = ctrl_r;
		period_nxt = period_r;
		cmp_nxt = cmp_r;
		dead_nxt = dead_r;
		cap_flag_nxt = cap_flag_r;
		if (wr_pend_r && u <= UNIT_LAST) begin
			case (reg_of(addr_r))
				REG_CTRL: ctrl_nxt[u] = hwdata[CTRL_W-1:0];
				REG_PERIOD: period_nxt[u] = hwdata[CNT_W-1:0];
				REG_CMP: cmp_nxt[u] = hwdata[CNT_W-1:0];
				REG_DEAD: dead_nxt[u] = hwdata[DEAD_W-1:0];
				REG_STAT: begin
					if (hwdata[STAT_CAP])
						cap_flag_nxt[u] = 1'b0;
				end
				default: cap_flag_nxt = cap_flag_r;
			endcase
		end
		// a capture in the same cycle as its clear is kept
		cap_flag_nxt = cap_flag_nxt | cap_evt;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NUM_UNITS; i++) begin
				ctrl_r[i] <= CTRL_RST;
				period_r[i] <= PERIOD_RST;
				cmp_r[i] <= CMP_RST;
				dead_r[i] <= DEAD_RST;
			end
			cap_flag_r <= '0;
		end else begin
			ctrl_r <= ctrl_nxt;
			period_r <= period_nxt;
			cmp_r <= cmp_nxt;
			dead_r <= dead_nxt;
			cap_flag_r <= cap_flag_nxt;
		end
	end

	// kill reaches the pins three edges after the pin moves, the cost of
	// synchronising it; the pins leave no room for an unclocked path
	genvar g;
	generate
		for (g = 0; g < NUM_UNITS; g++) begin : g_unit
			tcu_unit u_unit (
				.hclk(hclk),
				.hresetn(hresetn),
				.en_i(ctrl_r[g][CTRL_EN]),
				.reload_i(ctrl_r[g][CTRL_RELOAD]),
				.period_i(period_r[g]),
				.cmp_i(cmp_r[g]),
				.dead_i(dead_r[g]),
				.kill_true_i(ctrl_r[g][CTRL_KILL_T]),
				.kill_compl_i(ctrl_r[g][CTRL_KILL_C]),
				.cap_evt_i(cap_evt[g]),
				.kill_i(kill_s2_r[g]),
				.count_o(count_w[g]),
				.capt_o(capt_w[g]),
				.halted_o(halted_w[g]),
				.pwm_o(pwm_out[g]),
				.pwm_n_o(pwm_out_n[g])
			);
		end
	endgenerate

	sequence s_rd_accept;
		bus_st_r == BUS_IDLE && acc && !hwrite;
	endsequence

	sequence s_rd_answer;
		!hreadyout ##1 hreadyout;
	endsequence

	a_bus_read_wait: assert property (
		@(posedge hclk) disable iff (!hresetn)
		s_rd_accept |=> s_rd_answer)
		else $error("read answer not after one wait state");
	a_period_write: assert property (
		@(posedge hclk) disable iff (!hresetn)
		wr_pend_r && unit_of(addr_r) == 3'h0 &&
			reg_of(addr_r) == REG_PERIOD |=>
			period_r[0] == $past(hwdata[CNT_W-1:0]))
		else $error("period write not stored");
	a_cap_sticky: assert property (
		@(posedge hclk) disable iff (!hresetn)
		cap_evt[2] |=> cap_flag_r[2])
		else $error("capture flag lost");
	a_kill_pin: assert property (
		@(posedge hclk) disable iff (!hresetn)
		kill_pin[4] ##1 kill_pin[4] ##1 kill_pin[4] |=>
			pwm_out[4] == $past(ctrl_r[4][CTRL_KILL_T]))
		else $error("kill pin did not reach unit four");

	sequence s_wr_accept;
		bus_st_r == BUS_IDLE && acc && hwrite;
	endsequence

	// writes never stall the bus
	a_bus_write_nowait: assert property (
		@(posedge hclk) disable iff (!hresetn)
		s_wr_accept |=> hreadyout)
		else $error("write answer was delayed");
	a_hole_read: assert property (
		@(posedge hclk) disable iff (!hresetn)
		s_rd_accept and (unit_of(haddr[7:0]) > UNIT_LAST) |=>
			##1 hrdata == 32'h00000000)
		else $error("unmapped unit did not read zero");
	a_flag_clear: assert property (
		@(posedge hclk) disable iff (!hresetn)
		wr_pend_r && unit_of(addr_r) == 3'h2 &&
			reg_of(addr_r) == REG_STAT && hwdata[STAT_CAP] &&
			!cap_evt[2] |=> !cap_flag_r[2])
		else $error("capture flag not cleared");
	a_unit_apart: assert property (
		@(posedge hclk) disable iff (!hresetn)
		wr_pend_r && unit_of(addr_r) != 3'h4 |=>
			ctrl_r[4] == $past(ctrl_r[4]) &&
			period_r[4] == $past(period_r[4]))
		else $error("write to one unit changed another");

	// every unit forces its own pins while its synchronised kill stands
	generate
		for (g = 0; g < NUM_UNITS; g++) begin : g_kill_chk
			a_kill_each: assert property (
				@(posedge hclk) disable iff (!hresetn)
				kill_s2_r[g] |=>
					pwm_out[g] == $past(ctrl_r[g][CTRL_KILL_T]) &&
					pwm_out_n[g] == $past(ctrl_r[g][CTRL_KILL_C]))
				else $error("unit pins not at kill levels");
		end
	endgenerate
endmodule // tcu_top

// [logic/tcu_unit.sv]
// one timer/counter/pwm unit: counter, capture, compare, dead band, kill
module tcu_unit
	import tcu_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// configuration
	input wire logic en_i,
	input wire logic reload_i,
	input wire logic [CNT_W-1:0] period_i,
	input wire logic [CNT_W-1:0] cmp_i,
	input wire logic [DEAD_W-1:0] dead_i,
	input wire logic kill_true_i,
	input wire logic kill_compl_i,
	// synchronised events
	input wire logic cap_evt_i,
	input wire logic kill_i,
	// state
	output logic [CNT_W-1:0] count_o,
	output logic [CNT_W-1:0] capt_o,
	output logic halted_o,
	// pins
	output logic pwm_o,
	output logic pwm_n_o
);
	logic [CNT_W-1:0] count_r, count_nxt, capt_r, capt_nxt;
	logic halted_r, halted_nxt;
	logic raw_r, raw_nxt, raw_d_r;
	logic [DEAD_W-1:0] dt_r, dt_nxt;
	logic pwm_r, pwm_nxt, pwm_n_r, pwm_n_nxt;

	always_comb begin
		count_nxt = count_r;
		halted_nxt = halted_r;
		capt_nxt = capt_r;
		if (!en_i) begin
			count_nxt = '0;
			halted_nxt = 1'b0;
		end else if (!halted_r) begin
			if (count_r == period_i) begin
				if (reload_i)
					count_nxt = '0;
				else
					halted_nxt = 1'b1;
			end else begin
				count_nxt = count_r + 16'h0001;
			end
		end
		if (cap_evt_i)
			capt_nxt = count_r;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_r <= '0;
			halted_r <= 1'b0;
			capt_r <= '0;
		end else begin
			count_r <= count_nxt;
			halted_r <= halted_nxt;
			capt_r <= capt_nxt;
		end
	end

	// each edge of the compare signal blanks both outputs for dead_i cycles
	always_comb begin
		raw_nxt = en_i && (count_r < cmp_i);
		if (raw_r != raw_d_r)
			dt_nxt = dead_i;
		else if (dt_r != '0)
			dt_nxt = dt_r - 8'h01;
		else
			dt_nxt = '0;
		if (kill_i) begin
			pwm_nxt = kill_true_i;
			pwm_n_nxt = kill_compl_i;
		end else if (!en_i) begin
			pwm_nxt = 1'b0;
			pwm_n_nxt = 1'b0;
		end else begin
			pwm_nxt = raw_r && (dt_nxt == '0);
			pwm_n_nxt = !raw_r && (dt_nxt == '0);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			raw_r <= 1'b0;
			raw_d_r <= 1'b0;
			dt_r <= '0;
			pwm_r <= 1'b0;
			pwm_n_r <= 1'b0;
		end else begin
			raw_r <= raw_nxt;
			raw_d_r <= raw_r;
			dt_r <= dt_nxt;
			pwm_r <= pwm_nxt;
			pwm_n_r <= pwm_n_nxt;
		end
	end

	assign count_o = count_r;
	assign capt_o = capt_r;
	assign halted_o = halted_r;
	assign pwm_o = pwm_r;
	assign pwm_n_o = pwm_n_r;

	sequence s_running;
		en_i && !halted_r;
	endsequence

	a_count_step: assert property (
		@(posedge hclk) disable iff (!hresetn)
		s_running and (count_r != period_i) |=>
			!en_i || (count_r == $past(count_r) + 16'h0001))
		else $error("counter did not advance by one");
	a_count_reload: assert property (
		@(posedge hclk) disable iff (!hresetn)
		s_running and (count_r == period_i) and reload_i |=> count_r == '0)
		else $error("counter did not reload at period");
	a_count_halt: assert property (
		@(posedge hclk) disable iff (!hresetn)
		s_running and (count_r == period_i) and !reload_i |=>
			!en_i || (halted_r && count_r == $past(count_r)))
		else $error("counter did not stop at period");
	a_capture_latch: assert property (
		@(posedge hclk) disable iff (!hresetn)
		cap_evt_i |=> capt_r == $past(count_r))
		else $error("capture did not latch the count");
	a_compare_raw: assert property (
		@(posedge hclk) disable iff (!hresetn)
		en_i && (count_r < cmp_i) |=> raw_r)
		else $error("compare signal missing");
	a_kill_force: assert property (
		@(posedge hclk) disable iff (!hresetn)
		kill_i |=> pwm_r == $past(kill_true_i) &&
			pwm_n_r == $past(kill_compl_i))
		else $error("kill did not force outputs");
	a_dead_gap: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(pwm_r && pwm_n_r) |-> $past(kill_i))
		else $error("true and complement high together");
	a_dead_blank: assert property (
		@(posedge hclk) disable iff (!hresetn)
		$changed(raw_r) && dead_i != '0 && en_i && !kill_i |=>
			!pwm_r && !pwm_n_r)
		else $error("no dead band after edge");
endmodule // tcu_unit

// [shared/tcu_pkg.sv]
// constants shared by the timer/counter/pwm block
package tcu_pkg;
	localparam int NUM_UNITS = 5;
	localparam int CNT_W = 16;
	localparam int DEAD_W = 8;
	localparam int CTRL_W = 4;
	localparam logic [2:0] UNIT_LAST = 3'h4;
	// register index inside one unit (byte offset = index * 4)
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_PERIOD = 3'h1;
	localparam logic [2:0] REG_CMP = 3'h2;
	localparam logic [2:0] REG_DEAD = 3'h3;
	localparam logic [2:0] REG_COUNT = 3'h4;
	localparam logic [2:0] REG_CAPT = 3'h5;
	localparam logic [2:0] REG_STAT = 3'h6;
	// address fields: haddr[7:5] unit, haddr[4:2] register
	localparam int UNIT_LSB = 5;
	localparam int REG_LSB = 2;
	// control bits
	localparam int CTRL_EN = 0;
	localparam int CTRL_RELOAD = 1;
	localparam int CTRL_KILL_T = 2;
	localparam int CTRL_KILL_C = 3;
	// status bits
	localparam int STAT_HALT = 0;
	localparam int STAT_KILL = 1;
	localparam int STAT_CAP = 2;
	// reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
	localparam logic [CNT_W-1:0] PERIOD_RST = 16'hffff;
	localparam logic [CNT_W-1:0] CMP_RST = 16'h0000;
	localparam logic [DEAD_W-1:0] DEAD_RST = 8'h00;
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_RDWAIT = 1'b1
	} tcu_bus_st_t;
endpackage
